// ==== hdl/suspend_pin_pkg.sv ====
package suspend_pin_pkg;

  // ******************************
  // Register indices (byte address = 4 * index)
  // ******************************
  localparam logic [9:0] SUSP_LEVEL_IDX = 10'h06A;
  localparam logic [9:0] SUSP_DRIVE_IDX = 10'h06B;
  localparam logic [9:0] REVISION_IDX = 10'h260;
  localparam logic [9:0] BUS_STATUS_IDX = 10'h262;
  localparam int ADR_W = 12;
  localparam int IDX_LSB = 2;

  // ******************************
  // Field positions
  // ******************************
  localparam int OVERRIDE_BIT = 15;
  localparam int PIN_B_LEVEL_BIT = 13;
  localparam int PIN_B_SOURCE_LSB = 10;
  localparam int PIN_B_DRIVE_LSB = 8;
  localparam int PIN_A_LEVEL_BIT = 5;
  localparam int PIN_A_SOURCE_LSB = 2;
  localparam int PIN_A_DRIVE_LSB = 0;

  // ******************************
  // Masks and reset values
  // ******************************
  localparam logic [15:0] MANAGED_PINS = 16'h3CCF;
  localparam logic [15:0] SUSP_DRIVE_MASK = 16'hBCCF;
  localparam logic [15:0] SUSP_DRIVE_RST = 16'h0000;
  localparam logic [15:0] SUSP_LEVEL_RST = 16'h0000;
  localparam logic [2:0] SOURCE_RST = 3'h0;

  // ******************************
  // Source and drive codes
  // ******************************
  localparam logic [2:0] SRC_SUSP_OR_RESET = 3'h0;
  localparam logic [2:0] SRC_SUSP_ONLY = 3'h1;
  localparam logic [2:0] SRC_POWER_CLASS = 3'h2;
  localparam logic [1:0] DRIVE_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] DRIVE_PUSH_PULL = 2'h2;
  localparam logic [1:0] DRIVE_RST = DRIVE_PUSH_PULL;

  function automatic logic drive_code_valid(input logic [1:0] code);
    return (code == DRIVE_OPEN_DRAIN) || (code == DRIVE_PUSH_PULL);
  endfunction

endpackage

// ==== hdl/status_pin_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
module status_pin_driver
  import suspend_pin_pkg::*;
#(
  parameter bit LOW_ON_RESET_SOURCE = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] source_i,
  input wire logic [1:0] drive_i,
  input wire logic usb_suspend_i,
  input wire logic usb_bus_reset_i,
  input wire logic usb_configured_i,
  input wire logic high_power_i,
  output logic pin_o,
  output logic pin_oe_o
);

  logic active;
  logic level;

  always_comb
  begin
    unique case (source_i)
      SRC_SUSP_OR_RESET: active = usb_suspend_i | usb_bus_reset_i;
      SRC_SUSP_ONLY: active = usb_suspend_i;
      SRC_POWER_CLASS: active = usb_suspend_i | (high_power_i & ~usb_configured_i);
      default: active = 1'b0;
    endcase
  end

  // Pin A inverts only for the suspend-or-reset source
  assign level = (LOW_ON_RESET_SOURCE && source_i == SRC_SUSP_OR_RESET) ? ~active : active;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else if (drive_i == DRIVE_OPEN_DRAIN)
    begin
      pin_o <= 1'b0;
      pin_oe_o <= ~level;
    end
    else
    begin
      pin_o <= level;
      pin_oe_o <= 1'b1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  only_suspend_a: assert property ((source_i == SRC_SUSP_ONLY)
    && drive_i == DRIVE_PUSH_PULL
    && $stable(source_i) && $stable(drive_i) |=> pin_o == $past(usb_suspend_i))
    else $error("Suspend-only source does not follow suspend");
  reset_source_a: assert property ((source_i == SRC_SUSP_OR_RESET)
    && drive_i == DRIVE_PUSH_PULL
    && usb_bus_reset_i |=> pin_o == !LOW_ON_RESET_SOURCE)
    else $error("Bus reset does not assert status pin at the right level");
  open_drain_a: assert property (drive_i == DRIVE_OPEN_DRAIN |=> !pin_o)
    else $error("Open-drain status pin drives high");

endmodule
`default_nettype wire

// ==== hdl/suspend_pin_and_bus_status_control.sv ====
// Behaviour
// - No override: pins hold state during suspend
// - Override: suspend applies programmed levels and drives
// - Modem pins bits 13:10: 0 push-pull, 1 open-drain
// - Bits 7,6,3..0: 0 push-pull, 1 open-drain
// - Status bit 13 reads live pin B level
// - Status bit 5 reads live pin A level
// - Pin B source 000: high on suspend/reset
// - Pin A source 000: low on suspend/reset
// - Source 001: high only while suspended
// - Source 010: power class selects configuration term
// - Pin B drive: 01 open-drain, 10 push-pull
// - Pin A drive: 01 open-drain, 10 push-pull
// - Override suspend level follows level register bit
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module suspend_pin_and_bus_status_control
  import suspend_pin_pkg::*;
#(
  parameter logic [15:0] REVISION = 16'h0000, // Arbitrary value
  parameter int PINS = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus engine state
  input wire logic usb_suspend_i,
  input wire logic usb_bus_reset_i,
  input wire logic usb_configured_i,
  input wire logic high_power_i,
  // Normal pin drive from the serial and general-purpose logic
  input wire logic [PINS-1:0] normal_out_i,
  input wire logic [PINS-1:0] normal_oe_i,
  // Managed pins
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_o,
  // Status pins
  input wire logic bus_status_pin_a_i,
  output logic bus_status_pin_a_o,
  output logic bus_status_pin_a_oe_o,
  input wire logic bus_status_pin_b_i,
  output logic bus_status_pin_b_o,
  output logic bus_status_pin_b_oe_o
);

  // ************************************************
  // Register storage
  // ************************************************
  logic [15:0] suspend_drive_type;
  logic [15:0] suspend_level;
  logic [2:0] pin_a_source;
  logic [2:0] pin_b_source;
  logic [1:0] pin_a_drive;
  logic [1:0] pin_b_drive;

  logic [9:0] idx;
  logic req;
  logic wr;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] status_word;
  logic [15:0] next_read;
  logic override;

  assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
  // One access per request; the ack cycle itself is not taken again
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];
  assign override = suspend_drive_type[OVERRIDE_BIT];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] keep);
    return ((old & ~wmask) | (wdata & wmask)) & keep;
  endfunction

  // ************************************************
  // Bus handshake
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
    end
  end

  // ************************************************
  // Suspend drive and level registers
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      suspend_drive_type <= SUSP_DRIVE_RST;
    end
    else if (wr && idx == SUSP_DRIVE_IDX)
    begin
      // Reserved bits are not stored and read back as zero
      suspend_drive_type <= merge(suspend_drive_type, SUSP_DRIVE_MASK);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      suspend_level <= SUSP_LEVEL_RST;
    end
    else if (wr && idx == SUSP_LEVEL_IDX)
    begin
      suspend_level <= merge(suspend_level, MANAGED_PINS);
    end
  end

  // ************************************************
  // Status pin configuration
  // ************************************************
  logic [15:0] status_new;
  assign status_new = (status_word & ~wmask) | (wdata & wmask);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_a_source <= SOURCE_RST;
      pin_b_source <= SOURCE_RST;
    end
    else if (wr && idx == BUS_STATUS_IDX)
    begin
      // Reserved bits 15:14 and 7:6 are dropped
      pin_a_source <= status_new[PIN_A_SOURCE_LSB +: 3];
      pin_b_source <= status_new[PIN_B_SOURCE_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_a_drive <= DRIVE_RST;
      pin_b_drive <= DRIVE_RST;
    end
    else if (wr && idx == BUS_STATUS_IDX)
    begin
      // A bad code would leave the pin undefined, so it is ignored
      if (drive_code_valid(status_new[PIN_A_DRIVE_LSB +: 2]))
      begin
        pin_a_drive <= status_new[PIN_A_DRIVE_LSB +: 2];
      end
      if (drive_code_valid(status_new[PIN_B_DRIVE_LSB +: 2]))
      begin
        pin_b_drive <= status_new[PIN_B_DRIVE_LSB +: 2];
      end
    end
  end

  // ************************************************
  // Read path
  // ************************************************
  always_comb
  begin
    status_word = 16'h0000;
    status_word[PIN_B_LEVEL_BIT] = bus_status_pin_b_i;
    status_word[PIN_B_SOURCE_LSB +: 3] = pin_b_source;
    status_word[PIN_B_DRIVE_LSB +: 2] = pin_b_drive;
    status_word[PIN_A_LEVEL_BIT] = bus_status_pin_a_i;
    status_word[PIN_A_SOURCE_LSB +: 3] = pin_a_source;
    status_word[PIN_A_DRIVE_LSB +: 2] = pin_a_drive;
  end

  always_comb
  begin
    unique case (idx)
      SUSP_LEVEL_IDX: next_read = suspend_level;
      SUSP_DRIVE_IDX: next_read = suspend_drive_type;
      REVISION_IDX: next_read = REVISION;
      BUS_STATUS_IDX: next_read = status_word;
      default: next_read = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (req && !wb_we_i)
    begin
      wb_dat_o <= {16'h0000, next_read};
    end
  end

  // ************************************************
  // Suspend pin control
  // ************************************************
  logic [PINS-1:0] prog_out;
  logic [PINS-1:0] prog_oe;

  // Open-drain drives low for a zero and releases for a one
  assign prog_out = suspend_level & ~suspend_drive_type[PINS-1:0];
  assign prog_oe = ~(suspend_drive_type[PINS-1:0] & suspend_level);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= '0;
      pin_oe_o <= '0;
    end
    else if (!usb_suspend_i)
    begin
      pin_o <= normal_out_i;
      pin_oe_o <= normal_oe_i;
    end
    else if (override)
    begin
      pin_o <= (prog_out & MANAGED_PINS) | (normal_out_i & ~MANAGED_PINS);
      pin_oe_o <= (prog_oe & MANAGED_PINS) | (normal_oe_i & ~MANAGED_PINS);
    end
    else
    begin
      // Hold is from the last pre-suspend value, whatever the core does later
      pin_o <= pin_o;
      pin_oe_o <= pin_oe_o;
    end
  end

  // ************************************************
  // Status pins
  // ************************************************
  status_pin_driver #(
    .LOW_ON_RESET_SOURCE(1'b1)
  ) u_pin_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .source_i(pin_a_source),
    .drive_i(pin_a_drive),
    .usb_suspend_i(usb_suspend_i),
    .usb_bus_reset_i(usb_bus_reset_i),
    .usb_configured_i(usb_configured_i),
    .high_power_i(high_power_i),
    .pin_o(bus_status_pin_a_o),
    .pin_oe_o(bus_status_pin_a_oe_o)
  );

  status_pin_driver #(
    .LOW_ON_RESET_SOURCE(1'b0)
  ) u_pin_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .source_i(pin_b_source),
    .drive_i(pin_b_drive),
    .usb_suspend_i(usb_suspend_i),
    .usb_bus_reset_i(usb_bus_reset_i),
    .usb_configured_i(usb_configured_i),
    .high_power_i(high_power_i),
    .pin_o(bus_status_pin_b_o),
    .pin_oe_o(bus_status_pin_b_oe_o)
  );

  // ************************************************
  // Checks
  // ************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Ack is not a single cycle after request");

  ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("Ack given without a bus cycle");

  hold_pins_a: assert property (usb_suspend_i && !override |=> pin_o == $past(pin_o)
    && pin_oe_o == $past(pin_oe_o))
    else $error("Pins moved during suspend without override");

  follow_pins_a: assert property (!usb_suspend_i |=> pin_o == $past(normal_out_i)
    && pin_oe_o == $past(normal_oe_i))
    else $error("Pins do not follow normal drive outside suspend");

  suspend_level_a: assert property (usb_suspend_i && override |=>
    ((pin_o ^ $past(suspend_level)) & ~$past(suspend_drive_type) & MANAGED_PINS) == '0)
    else $error("Push-pull suspend level differs from level register");

  modem_drive_a: assert property (usb_suspend_i && override |=>
    (pin_oe_o[13:10] == ~($past(suspend_drive_type[13:10]) & $past(suspend_level[13:10]))))
    else $error("Modem pin drive type wrong in suspend");

  serial_drive_a: assert property (usb_suspend_i && override |=>
    (pin_oe_o[3:0] == ~($past(suspend_drive_type[3:0]) & $past(suspend_level[3:0])))
    && (pin_oe_o[7:6] == ~($past(suspend_drive_type[7:6]) & $past(suspend_level[7:6]))))
    else $error("Serial pin drive type wrong in suspend");

  drive_write_a: assert property (wr && idx == SUSP_DRIVE_IDX && wb_sel_i[1:0] == 2'b11
    |=> suspend_drive_type == ($past(wdata) & SUSP_DRIVE_MASK))
    else $error("Suspend drive register write not stored");

  level_write_a: assert property (wr && idx == SUSP_LEVEL_IDX && wb_sel_i[1:0] == 2'b11
    |=> suspend_level == ($past(wdata) & MANAGED_PINS))
    else $error("Suspend level register write not stored");

  pin_b_read_a: assert property (req && !wb_we_i && idx == BUS_STATUS_IDX |=>
    wb_dat_o[PIN_B_LEVEL_BIT] == $past(bus_status_pin_b_i))
    else $error("Pin B level not returned on read");

  pin_a_read_a: assert property (req && !wb_we_i && idx == BUS_STATUS_IDX |=>
    wb_dat_o[PIN_A_LEVEL_BIT] == $past(bus_status_pin_a_i))
    else $error("Pin A level not returned on read");

  status_rsvd_a: assert property (req && !wb_we_i && idx == BUS_STATUS_IDX |=>
    wb_dat_o[31:16] == 16'h0000 && wb_dat_o[15:14] == 2'b00 && wb_dat_o[7:6] == 2'b00)
    else $error("Status reserved bits read nonzero");

  revision_read_a: assert property (req && !wb_we_i && idx == REVISION_IDX
    |=> wb_dat_o == {16'h0000, REVISION})
    else $error("Revision read returns wrong value");

  unmapped_read_a: assert property (req && !wb_we_i && idx != SUSP_LEVEL_IDX
    && idx != SUSP_DRIVE_IDX && idx != REVISION_IDX && idx != BUS_STATUS_IDX
    |=> wb_dat_o == 32'h0000_0000)
    else $error("Unmapped read returns nonzero data");

  bad_drive_a: assert property (wr && idx == BUS_STATUS_IDX && wb_sel_i[0]
    && !drive_code_valid(wdata[PIN_A_DRIVE_LSB +: 2]) |=> $stable(pin_a_drive))
    else $error("Invalid drive code changed pin A drive");

  bad_drive_b_a: assert property (wr && idx == BUS_STATUS_IDX && wb_sel_i[1]
    && !drive_code_valid(wdata[PIN_B_DRIVE_LSB +: 2]) |=> $stable(pin_b_drive))
    else $error("Invalid drive code changed pin B drive");

  drive_valid_a: assert property (drive_code_valid(pin_a_drive)
    && drive_code_valid(pin_b_drive))
    else $error("Status pin drive holds invalid code");

endmodule
`default_nettype wire

// ==== verification/pad_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************
// External pad with a resistor load
// ******************************
module pad_load_model
#(
  parameter bit PULL_UP = 1'b1
)
(
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic level_o
);
  // Released open-drain line settles to the resistor level
  assign level_o = pin_oe_i ? pin_i : PULL_UP;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import suspend_pin_pkg::*;
;
  localparam logic [15:0] REV_VAL = 16'h5A3C; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic susp = 1'b0;
  logic bus_rst = 1'b0;
  logic cfg = 1'b0;
  logic hp = 1'b0;
  logic [15:0] n_out = 16'h0000;
  logic [15:0] n_oe = 16'h0000;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic a_o, a_oe, b_o, b_oe, a_pad, b_pad;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h0001_39BC;
  logic [31:0] exp_q[$];

  suspend_pin_and_bus_status_control #(.REVISION(REV_VAL), .PINS(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .usb_suspend_i(susp), .usb_bus_reset_i(bus_rst),
    .usb_configured_i(cfg), .high_power_i(hp), .normal_out_i(n_out), .normal_oe_i(n_oe),
    .pin_o(pin_out), .pin_oe_o(pin_oe), .bus_status_pin_a_i(a_pad),
    .bus_status_pin_a_o(a_o), .bus_status_pin_a_oe_o(a_oe), .bus_status_pin_b_i(b_pad),
    .bus_status_pin_b_o(b_o), .bus_status_pin_b_oe_o(b_oe));
  pad_load_model pad_a (.pin_i(a_o), .pin_oe_i(a_oe), .level_o(a_pad));
  pad_load_model pad_b (.pin_i(b_o), .pin_oe_i(b_oe), .level_o(b_pad));

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[23:8];
  endfunction

  // Codes above 010 leave the pin idle
  function automatic logic act(input logic [2:0] s, input logic [3:0] u);
    case (s)
      3'h0: return u[0] | u[1];
      3'h1: return u[0];
      3'h2: return u[0] | (u[3] & ~u[2]);
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wb_xfer(input logic [9:0] idx, input logic we, input logic [15:0] d);
    int t;
    t = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h3;
    wb_dat_w <= {16'h0000, d};
    @(posedge clk_i);
    // Only the watchdog ends a wait that never sees ack
    while (wb_ack !== 1'b1)
    begin
      @(posedge clk_i);
      t++;
    end
    chk("wb_ack_lat", 32'h0000_0001, 32'(t));
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_read(input logic [9:0] idx, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    wb_xfer(idx, 1'b0, 16'h0000);
  endtask

  task automatic check_pins(input logic [15:0] eo, input logic [15:0] ee);
    chk("pin_oe", 32'(ee), 32'(pin_oe));
    chk("pin_out", 32'(eo & ee), 32'(pin_out & ee));
  endtask

  // ******************************
  // Clock, monitor, watchdog
  // ******************************
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
      chk("rd_data", exp_q.pop_front(), wb_dat_r);
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    final_report();
  end

  // ******************************
  // Main sequence
  // ******************************
  initial
  begin
    logic [15:0] d, l, n0o, n0e, m;
    logic [2:0] sa, sb;
    logic [1:0] ca, cb;
    logic la, lb;
    m = MANAGED_PINS;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_read(SUSP_DRIVE_IDX, SUSP_DRIVE_RST);
    wb_read(SUSP_LEVEL_IDX, SUSP_LEVEL_RST);
    wb_read(BUS_STATUS_IDX, 16'h0222);
    wb_read(REVISION_IDX, REV_VAL);
    wb_read(10'h100, 16'h0000);
    // Hold without override; every pin freezes at its last value
    d = rnd() & m;
    wb_xfer(SUSP_DRIVE_IDX, 1'b1, d);
    wb_read(SUSP_DRIVE_IDX, d);
    n0o = rnd();
    n0e = rnd();
    n_out <= n0o;
    n_oe <= n0e;
    repeat (2) @(posedge clk_i);
    susp <= 1'b1;
    @(posedge clk_i);
    n_out <= rnd();
    n_oe <= rnd();
    repeat (3) @(posedge clk_i);
    check_pins(n0o, n0e);
    susp <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_pins(n_out, n_oe);
    repeat (4)
    begin
      d = (rnd() & m) | 16'h8000;
      l = rnd() & m;
      wb_xfer(SUSP_DRIVE_IDX, 1'b1, d);
      wb_xfer(SUSP_LEVEL_IDX, 1'b1, l);
      wb_read(SUSP_LEVEL_IDX, l);
      n_out <= rnd();
      n_oe <= rnd();
      susp <= 1'b1;
      repeat (3) @(posedge clk_i);
      check_pins((l & m) | (n_out & ~m), (~(d & l) & m) | (n_oe & ~m));
      susp <= 1'b0;
      @(posedge clk_i);
    end
    // Status pins: sources, drives, live levels
    repeat (12)
    begin
      d = rnd();
      sa = {d[12], d[1:0]};
      sb = {d[13], d[3:2]};
      ca = d[6] ? DRIVE_OPEN_DRAIN : DRIVE_PUSH_PULL;
      cb = d[7] ? DRIVE_OPEN_DRAIN : DRIVE_PUSH_PULL;
      {hp, cfg, bus_rst, susp} <= d[11:8];
      wb_xfer(BUS_STATUS_IDX, 1'b1, {3'b000, sb, cb, 3'b000, sa, ca});
      wb_xfer(BUS_STATUS_IDX, 1'b1, {3'b000, sb, {2{d[14]}}, 3'b000, sa, {2{d[15]}}});
      repeat (2) @(posedge clk_i);
      la = act(sa, d[11:8]) ^ (sa == 3'h0);
      lb = act(sb, d[11:8]);
      chk("pin_a", 32'({d[6] ? 1'b0 : la, d[6] ? ~la : 1'b1}), 32'({a_o, a_oe}));
      chk("pin_b", 32'({d[7] ? 1'b0 : lb, d[7] ? ~lb : 1'b1}), 32'({b_o, b_oe}));
      wb_read(BUS_STATUS_IDX, {2'b00, lb, sb, cb, 2'b00, la, sa, ca});
    end
    final_report();
  end
endmodule
`default_nettype wire
